// *** hdl/iet_interrupt_event_trap_unit.sv ***
// Interrupt nodes, event transfer channels and trap handling for the CPU.
`timescale 1ns/10ps
module iet_interrupt_event_trap_unit #(
    parameter int N  = iet_pkg::NODES,
    parameter int NC = iet_pkg::CHANNELS,
    parameter int PW = iet_pkg::PRIO_W,
    parameter int AW = iet_pkg::PTR_W,
    parameter int CW = iet_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_b_i,
    // Node sources and configuration
    input  wire logic [N-1:0]         periph_req_i,
    input  wire logic [3:0]           shared_src_i,
    input  wire logic [2*iet_pkg::SHARED_N-1:0] src_sel_i,
    input  wire logic [N-1:0]         sw_set_i,
    input  wire logic [N-1:0]         node_en_i,
    input  wire logic [N*PW-1:0]      node_prio_i,
    input  wire logic [N-1:0]         node_to_etc_i,
    input  wire logic [N*3-1:0]       node_etc_ch_i,
    input  wire logic [PW-1:0]        cpu_level_i,
    input  wire logic                 jump_cache_i,
    // Transfer channel configuration
    input  wire logic [NC-1:0]        chan_load_i,
    input  wire logic [AW-1:0]        chan_src_i,
    input  wire logic [AW-1:0]        chan_dst_i,
    input  wire logic [CW-1:0]        chan_cnt_i,
    input  wire logic [NC-1:0]        chan_inc_src_i,
    input  wire logic [NC-1:0]        chan_inc_dst_i,
    input  wire logic [NC-1:0]        chan_byte_i,
    input  wire logic [NC-1:0]        chan_cont_i,
    // External request router
    input  wire logic [3:0]           eru_in_i,
    input  wire logic [3:0]           eru_rise_i,
    input  wire logic [3:0]           eru_fall_i,
    input  wire logic [15:0]          eru_route_i,
    input  wire logic [3:0]           eru_pat_mask_i,
    input  wire logic [3:0]           eru_pat_i,
    input  wire logic [7:0]           eru_gate_i,
    // Traps
    input  wire logic [5:0]           hw_trap_i,
    input  wire logic [2:0]           esr_pin_i,
    input  wire logic [2:0]           esr_en_i,
    input  wire logic [2:0]           esr_to_one_i,
    input  wire logic [7:0]           trap_clr_i,
    input  wire logic                 trap_done_i,
    input  wire logic                 sw_trap_i,
    input  wire logic [7:0]           sw_trap_num_i,
    // CPU side
    output logic                      branch_o,
    output logic [7:0]                vector_o,
    output logic                      cpu_stall_o,
    // Memory side of the transfer channels
    output logic                      etc_xfer_o,
    output logic [AW-1:0]             etc_src_o,
    output logic [AW-1:0]             etc_dst_o,
    output logic                      etc_byte_o,
    // Status
    output logic [N-1:0]              node_req_o,
    output logic [NC*CW-1:0]          chan_cnt_o,
    output logic [7:0]                trap_flag_o,
    output logic                      trap_busy_o,
    output logic [3:0]                eru_evt_o
);

    // ----------------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------------
    iet_pkg::iet_state_e state_reg;
    logic [N-1:0]        req_reg;
    logic [N-1:0]        src_vec;
    logic [N-1:0]        clr_vec;
    logic [AW-1:0]       src_ptr_reg [NC];
    logic [AW-1:0]       dst_ptr_reg [NC];
    logic [2:0]          esr_prev_reg;
    logic [2:0]          esr_rise;
    logic [7:0]          trap_src;
    logic [7:0]          trap_pend_reg;
    logic [2:0]          cur_trap_reg;
    logic                sw_pend_reg;
    logic [7:0]          sw_num_reg;
    logic [6:0]          win_idx;
    logic [PW-1:0]       win_prio;
    logic                win_valid;
    logic [6:0]          wait_idx_reg;
    logic [3:0]          wait_cnt_reg;
    logic [2:0]          trap_idx;
    logic [2:0]          win_ch;
    logic [CW-1:0]       win_cnt;
    logic                win_cont;
    logic                trap_go;
    logic                sw_go;
    logic                pick_ok;
    logic                etc_go;
    logic                wait_go;
    logic                int_go;

    // Lowest set index of a trap vector; index 0 wins.
    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = iet_pkg::TRAP_IDLE_IDX;
        for (int i = 7; i >= 0; i--)
            if (v[i])
                r = 3'(i);
        return r;
    endfunction

    // Byte transfers step a pointer by one, word transfers by two.
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p, input logic inc, input logic b);
        logic [AW-1:0] r;
        r = p;
        if (inc)
            r = b ? p + AW'(1) : p + AW'(2);
        return r;
    endfunction

    // ----------------------------------------------------------------------
    // Request sources
    // ----------------------------------------------------------------------
    iet_ext_router #(
        .CH (iet_pkg::ERU_CH)
    ) u_router (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .in_i       (eru_in_i),
        .rise_i     (eru_rise_i),
        .fall_i     (eru_fall_i),
        .route_i    (eru_route_i),
        .pat_mask_i (eru_pat_mask_i),
        .pat_i      (eru_pat_i),
        .gate_i     (eru_gate_i),
        .evt_o      (eru_evt_o)
    );

    always_comb
    begin
        src_vec = periph_req_i;
        for (int s = 0; s < iet_pkg::SHARED_N; s++)
            src_vec[iet_pkg::SHARED_BASE+s] = shared_src_i[src_sel_i[2*s +: 2]];
        for (int e = 0; e < iet_pkg::ERU_CH; e++)
            src_vec[iet_pkg::ERU_BASE+e] = periph_req_i[iet_pkg::ERU_BASE+e] | eru_evt_o[e];
    end

    // ----------------------------------------------------------------------
    // Arbitration among enabled pending nodes
    // ----------------------------------------------------------------------
    // A strict compare keeps the lowest node index on equal priority.
    always_comb
    begin
        win_idx   = '0;
        win_prio  = cpu_level_i;
        win_valid = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            if (req_reg[i] && node_en_i[i] && node_prio_i[i*PW +: PW] > win_prio)
            begin
                win_idx   = 7'(i);
                win_prio  = node_prio_i[i*PW +: PW];
                win_valid = 1'b1;
            end
        end
    end

    assign win_ch   = node_etc_ch_i[win_idx*3 +: 3];
    assign win_cnt  = chan_cnt_o[win_ch*CW +: CW];
    assign win_cont = chan_cont_i[win_ch];
    assign trap_idx = first_set(trap_pend_reg);

    // ----------------------------------------------------------------------
    // Dispatch decisions
    // ----------------------------------------------------------------------
    assign trap_go = (trap_pend_reg != '0) && (!trap_busy_o || trap_idx < cur_trap_reg);
    assign sw_go   = !trap_go && !trap_busy_o && sw_pend_reg && state_reg == iet_pkg::ST_IDLE;
    assign pick_ok = !trap_go && !trap_busy_o && !sw_pend_reg && state_reg == iet_pkg::ST_IDLE
                     && win_valid;
    assign etc_go  = pick_ok && node_to_etc_i[win_idx] && (win_cnt != '0 || win_cont);
    assign wait_go = pick_ok && !etc_go;
    assign int_go  = !trap_go && state_reg == iet_pkg::ST_WAIT && wait_cnt_reg == '0;

    // A transfer that brings the counter to zero leaves the flag set for the interrupt.
    always_comb
    begin
        clr_vec = '0;
        if (etc_go && !(win_cnt == CW'(1) && !win_cont))
            clr_vec[win_idx] = 1'b1;
        if (int_go)
            clr_vec[wait_idx_reg] = 1'b1;
    end

    // ----------------------------------------------------------------------
    // Request flags
    // ----------------------------------------------------------------------
    // A new request in the cycle of its clear survives.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            req_reg <= '0;
        else
            req_reg <= (req_reg & ~clr_vec) | src_vec | sw_set_i;
    end

    assign node_req_o = req_reg;

    // ----------------------------------------------------------------------
    // Response state machine
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg    <= iet_pkg::ST_IDLE;
            wait_idx_reg <= '0;
            wait_cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                iet_pkg::ST_IDLE:
                begin
                    if (wait_go)
                    begin
                        state_reg    <= iet_pkg::ST_WAIT;
                        wait_idx_reg <= win_idx;
                        wait_cnt_reg <= jump_cache_i ? 4'(iet_pkg::LAT_JC_CYC - 3)
                                                     : 4'(iet_pkg::LAT_NJC_CYC - 3);
                    end
                end
                iet_pkg::ST_WAIT:
                begin
                    // A trap abandons the wait; the node flag stays set for later.
                    if (trap_go || int_go)
                        state_reg <= iet_pkg::ST_IDLE;
                    else
                        wait_cnt_reg <= wait_cnt_reg - 4'(1);
                end
                default:
                    state_reg <= iet_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Branch requests to the CPU
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            branch_o <= 1'b0;
            vector_o <= '0;
        end
        else
        begin
            branch_o <= trap_go || sw_go || int_go;
            if (trap_go)
                vector_o <= iet_pkg::TRAP_VEC_BASE + 8'(trap_idx);
            else if (sw_go)
                vector_o <= sw_num_reg;
            else if (int_go)
                vector_o <= 8'(wait_idx_reg);
        end
    end

    // ----------------------------------------------------------------------
    // Event transfer channels
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int c = 0; c < NC; c++)
            begin
                src_ptr_reg[c]         <= iet_pkg::PTR_RST;
                dst_ptr_reg[c]         <= iet_pkg::PTR_RST;
                chan_cnt_o[c*CW +: CW] <= iet_pkg::CNT_RST;
            end
        end
        else
        begin
            for (int c = 0; c < NC; c++)
            begin
                if (chan_load_i[c])
                begin
                    src_ptr_reg[c]         <= chan_src_i;
                    dst_ptr_reg[c]         <= chan_dst_i;
                    chan_cnt_o[c*CW +: CW] <= chan_cnt_i;
                end
                else if (etc_go && win_ch == 3'(c))
                begin
                    src_ptr_reg[c] <= step(src_ptr_reg[c], chan_inc_src_i[c], chan_byte_i[c]);
                    dst_ptr_reg[c] <= step(dst_ptr_reg[c], chan_inc_dst_i[c], chan_byte_i[c]);
                    if (!chan_cont_i[c])
                        chan_cnt_o[c*CW +: CW] <= chan_cnt_o[c*CW +: CW] - CW'(1);
                end
            end
        end
    end

    // The transfer is presented for one cycle while the CPU is held.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            etc_xfer_o  <= 1'b0;
            cpu_stall_o <= 1'b0;
            etc_src_o   <= '0;
            etc_dst_o   <= '0;
            etc_byte_o  <= 1'b0;
        end
        else
        begin
            etc_xfer_o  <= etc_go;
            cpu_stall_o <= etc_go;
            if (etc_go)
            begin
                etc_src_o  <= src_ptr_reg[win_ch];
                etc_dst_o  <= dst_ptr_reg[win_ch];
                etc_byte_o <= chan_byte_i[win_ch];
            end
        end
    end

    // ----------------------------------------------------------------------
    // Traps and service request pins
    // ----------------------------------------------------------------------
    assign esr_rise = esr_pin_i & ~esr_prev_reg & esr_en_i;

    always_comb
    begin
        trap_src                = {hw_trap_i, 2'b00};
        trap_src[iet_pkg::TRAP_SR0] = |(esr_rise & ~esr_to_one_i);
        trap_src[iet_pkg::TRAP_SR1] = |(esr_rise & esr_to_one_i);
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            esr_prev_reg  <= '0;
            trap_flag_o   <= '0;
            trap_pend_reg <= '0;
        end
        else
        begin
            esr_prev_reg <= esr_pin_i;
            // Set wins over a software clear in the same cycle.
            trap_flag_o  <= (trap_flag_o & ~trap_clr_i) | trap_src;
            trap_pend_reg <= (trap_pend_reg & ~(trap_go ? 8'(1) << trap_idx : 8'h00)) | trap_src;
        end
    end

    // Nesting depth is one: finishing a pre-empting trap ends the busy state.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            trap_busy_o  <= 1'b0;
            cur_trap_reg <= iet_pkg::TRAP_IDLE_IDX;
        end
        else if (trap_go)
        begin
            trap_busy_o  <= 1'b1;
            cur_trap_reg <= trap_idx;
        end
        else if (trap_done_i)
        begin
            trap_busy_o  <= 1'b0;
            cur_trap_reg <= iet_pkg::TRAP_IDLE_IDX;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sw_pend_reg <= 1'b0;
            sw_num_reg  <= '0;
        end
        else if (sw_trap_i && !sw_pend_reg)
        begin
            sw_pend_reg <= 1'b1;
            sw_num_reg  <= sw_trap_num_i;
        end
        else if (sw_go)
            sw_pend_reg <= 1'b0;
    end

endmodule // iet_interrupt_event_trap_unit

// *** shared/iet_pkg.sv ***
// Package of constants for the interrupt, event transfer and trap unit.
// ----------------------------------------------------------------------
// Notes on behaviour
// - Each node is routed to vectored interrupt service or to a transfer channel.
// - Standard service branches to the node's vector table entry.
// - A channel transfer steals exactly one cycle from the CPU.
// - A transfer moves a byte or word, then bumps source and/or destination pointer.
// - Channel counter decrements per transfer, except in continuous mode.
// - Counter reaching zero turns the source's next service into a standard interrupt.
// - Eight independent transfer channels.
// - Request to branch takes 7 clocks with jump cache, 11 without.
// - 96 nodes, each with request flag, enable flag and priority field.
// - A group of shared nodes picks its source through source select inputs.
// - External router has 4 inputs, a routing matrix and 4 gating units.
// - Router inputs detect rising, falling or both edges.
// - Gating units combine events and pass them on pattern match or miss.
// - A hardware trap branches at once to its own vector location.
// - Each trap occurrence sets its own bit in the trap flag register.
// - A trap pre-empts anything except a trap service of higher or equal priority.
// - A running trap service is not pre-empted by interrupts or transfers.
// - Three service request pins derive system request zero and one traps.
// - A software trap with a number invokes that vector's service.
// - Software setting a request flag raises the request like hardware.
// ----------------------------------------------------------------------
package iet_pkg;

    localparam int NODES       = 96;
    localparam int CHANNELS    = 8;
    localparam int TRAPS       = 8;
    localparam int PRIO_W      = 4;
    localparam int PTR_W       = 24;
    localparam int CNT_W       = 8;
    localparam int VEC_W       = 8;
    localparam int ERU_CH      = 4;
    localparam int ESR_PINS    = 3;
    localparam int SHARED_BASE = 80;
    localparam int SHARED_N    = 4;
    localparam int ERU_BASE    = 92;

    // Response counts in CPU clocks, request pulse to branch.
    localparam int LAT_JC_CYC  = 7;
    localparam int LAT_NJC_CYC = 11;

    // Trap numbering: index 0 is the highest priority.
    localparam int TRAP_SR0    = 0;
    localparam int TRAP_SR1    = 1;
    localparam logic [VEC_W-1:0] TRAP_VEC_BASE = 8'h60;
    localparam logic [2:0]       TRAP_IDLE_IDX = 3'h7;

    localparam logic [PTR_W-1:0] PTR_RST = 24'h00_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } iet_state_e;

endpackage

// *** hdl/iet_ext_router.sv ***
// External request router: edge trigger logic, routing matrix and output gating.
`timescale 1ns/10ps
module iet_ext_router #(
    parameter int CH = 4
) (
    // Clock and reset
    input  wire logic            clk_sys_i,
    input  wire logic            rst_b_i,
    // Inputs and trigger selection
    input  wire logic [CH-1:0]   in_i,
    input  wire logic [CH-1:0]   rise_i,
    input  wire logic [CH-1:0]   fall_i,
    // Routing matrix, bit o*CH+i sends input i to output o
    input  wire logic [CH*CH-1:0] route_i,
    // Gating: pattern over input levels and two mode bits per output
    input  wire logic [CH-1:0]   pat_mask_i,
    input  wire logic [CH-1:0]   pat_i,
    input  wire logic [2*CH-1:0] gate_i,
    // Gated events
    output logic      [CH-1:0]   evt_o
);

    logic [CH-1:0] prev_reg;
    logic [CH-1:0] edge_evt;
    logic          pat_hit;

    // ----------------------------------------------------------------------
    // Edge trigger logic
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            prev_reg <= '0;
        else
            prev_reg <= in_i;
    end

    // Both edges are detected when both selects are set.
    assign edge_evt = (rise_i & in_i & ~prev_reg) | (fall_i & ~in_i & prev_reg);
    assign pat_hit  = ((in_i ^ pat_i) & pat_mask_i) == '0;

    // ----------------------------------------------------------------------
    // Routing matrix and output gating
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            evt_o <= '0;
        else
        begin
            for (int o = 0; o < CH; o++)
            begin
                case (gate_i[2*o +: 2])
                    2'b01:   evt_o[o] <= |(edge_evt & route_i[o*CH +: CH]);
                    2'b10:   evt_o[o] <= |(edge_evt & route_i[o*CH +: CH]) & pat_hit;
                    2'b11:   evt_o[o] <= |(edge_evt & route_i[o*CH +: CH]) & ~pat_hit;
                    default: evt_o[o] <= 1'b0;
                endcase
            end
        end
    end

endmodule // iet_ext_router

// *** test/iet_unit_assertions.sv ***
// Concurrent checks on the trap unit ports.
`timescale 1ns/10ps
module iet_unit_assertions (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    // Requests
    input wire logic [95:0] periph_req_i,
    input wire logic [95:0] sw_set_i,
    input wire logic [3:0]  eru_in_i,
    input wire logic [3:0]  eru_rise_i,
    input wire logic [15:0] eru_route_i,
    input wire logic [7:0]  eru_gate_i,
    input wire logic [5:0]  hw_trap_i,
    input wire logic        trap_done_i,
    // Responses
    input wire logic        branch_o,
    input wire logic [7:0]  vector_o,
    input wire logic        cpu_stall_o,
    input wire logic        etc_xfer_o,
    input wire logic [95:0] node_req_o,
    input wire logic [7:0]  trap_flag_o,
    input wire logic        trap_busy_o,
    input wire logic [3:0]  eru_evt_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    // --------------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------------
    property p_trap_flag; hw_trap_i[0] |=> trap_flag_o[2]; endproperty
    a_trap_flag: assert property (p_trap_flag) else $error("no trap flag");
    property p_trap_br; hw_trap_i != 6'h00 && !trap_busy_o |-> ##2 branch_o && vector_o[7:3] == 5'h0C; endproperty
    a_trap_br: assert property (p_trap_br) else $error("trap late");
    property p_busy_hold; trap_busy_o && !trap_done_i |=> trap_busy_o; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
    // Inside a trap service only traps branch.
    property p_busy_vec; $past(trap_busy_o) && trap_busy_o && branch_o |-> vector_o[7:3] == 5'h0C; endproperty
    a_busy_vec: assert property (p_busy_vec) else $error("trap pre-empted");
    property p_steal; etc_xfer_o || cpu_stall_o |-> etc_xfer_o && cpu_stall_o && !branch_o; endproperty
    a_steal: assert property (p_steal) else $error("bad steal");
    property p_node_flag; $rose(periph_req_i[5]) |=> node_req_o[5]; endproperty
    a_node_flag: assert property (p_node_flag) else $error("no node flag");
    property p_sw_set; sw_set_i[6] |=> node_req_o[6]; endproperty
    a_sw_set: assert property (p_sw_set) else $error("no sw flag");
    property p_edge; $rose(eru_in_i[2]) && eru_rise_i[2] && eru_route_i[6] && eru_gate_i[3:2] == 2'h1 |=> eru_evt_o[1];
    endproperty
    a_edge: assert property (p_edge) else $error("edge lost");
    property p_gate_off; eru_gate_i[3:2] == 2'h0 |=> !eru_evt_o[1]; endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate leak");
    c_vect: cover property (branch_o && vector_o < 8'h60);
    c_xfer: cover property (etc_xfer_o);
    c_done: cover property (trap_busy_o && trap_done_i);
endmodule // iet_unit_assertions

bind iet_interrupt_event_trap_unit iet_unit_assertions i_chk (.*);

// *** test/iet_cpu_model.sv ***
// CPU model ending each trap service after a dwell.
`timescale 1ns/10ps
module iet_cpu_model #(
    parameter int DWELL = 12
) (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // Trap service handshake
    input  wire logic trap_busy_i,
    output logic      trap_done_o
);
    int unsigned cnt_reg;
    // One-cycle end pulse, so the next service is not cut short.
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_reg     <= 0;
            trap_done_o <= 1'b0;
        end
        else
        begin
            trap_done_o <= trap_busy_i && !trap_done_o && cnt_reg == DWELL;
            cnt_reg     <= (trap_busy_i && cnt_reg < DWELL) ? cnt_reg + 1 : 0;
        end
    end
endmodule // iet_cpu_model

// *** test/testbench.sv ***
// Self-checking bench for the trap unit.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    logic         clk = 1'b0, rst_b = 1'b0, jc = 1'b1, swt = 1'b0, tdone;
    logic [95:0]  preq = '0, sws = '0, n2e = '0, nen = 96'hDFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
    logic [383:0] prio = {{88{4'h2}}, 4'h9, {7{4'h2}}};
    logic [287:0] ech = '0;
    logic [23:0]  csrc = 24'h00_0100, cdst = 24'h00_0200;
    logic [7:0]   ld = '0, ccfg = 8'h02, incs = 8'hFF, incd = 8'hFF, byt = '0, cont = '0;
    logic [7:0]   gate = '0, swn = '0, tclr = '0;
    logic [5:0]   htr = '0;
    logic [3:0]   ein = '0, rise = '0, fall = '0, pmask = '0, pat = '0, lvl = '0;
    logic [15:0]  rte = '0;
    logic         branch, stall, xfer, ebyte, tbusy;
    logic [7:0]   vec, tflag;
    logic [23:0]  esrc, edst;
    logic [95:0]  nreq;
    logic [63:0]  ccnt;
    logic [3:0]   evt;
    int           miscompares = 0, checked = 0;

    always #25 clk = ~clk;

    iet_interrupt_event_trap_unit i_dut (.clk_sys_i(clk), .rst_b_i(rst_b), .periph_req_i(preq),
        .shared_src_i(4'h0), .src_sel_i(8'h00), .sw_set_i(sws), .node_en_i(nen), .node_prio_i(prio),
        .node_to_etc_i(n2e), .node_etc_ch_i(ech), .cpu_level_i(lvl), .jump_cache_i(jc), .chan_load_i(ld),
        .chan_src_i(csrc), .chan_dst_i(cdst), .chan_cnt_i(ccfg), .chan_inc_src_i(incs), .chan_inc_dst_i(incd),
        .chan_byte_i(byt), .chan_cont_i(cont), .eru_in_i(ein), .eru_rise_i(rise), .eru_fall_i(fall),
        .eru_route_i(rte), .eru_pat_mask_i(pmask), .eru_pat_i(pat), .eru_gate_i(gate), .hw_trap_i(htr),
        .esr_pin_i(3'h0), .esr_en_i(3'h0), .esr_to_one_i(3'h0), .trap_clr_i(tclr), .trap_done_i(tdone),
        .sw_trap_i(swt), .sw_trap_num_i(swn), .branch_o(branch), .vector_o(vec), .cpu_stall_o(stall),
        .etc_xfer_o(xfer), .etc_src_o(esrc), .etc_dst_o(edst), .etc_byte_o(ebyte), .node_req_o(nreq),
        .chan_cnt_o(ccnt), .trap_flag_o(tflag), .trap_busy_o(tbusy), .eru_evt_o(evt));

    iet_cpu_model i_cpu (.clk_sys_i(clk), .rst_b_i(rst_b), .trap_busy_i(tbusy), .trap_done_o(tdone));

    // --------------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------------
    task automatic pulse(input logic [95:0] r, s, input logic [5:0] t);
        {preq, sws, htr} <= {r, s, t};
        @(posedge clk);
        {preq, sws, htr} <= '0;
        @(posedge clk);
    endtask

    // Counts from the edge that takes the request.
    task automatic wait_for(input logic want_xfer, output int n);
        n = 1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((want_xfer ? xfer : branch) !== 1'b1 && n < 60);
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // --------------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------------
    task automatic t_vectored();
        int n;
        for (int j = 0; j < 2; j++)
        begin
            jc <= j[0];
            pulse(96'h20, '0, '0);
            wait_for(1'b0, n);
            `CHK("latency", j ? 7 : 11, n)
            `CHK("vector", 8'h05, vec)
        end
        pulse('0, 96'hC0, '0);
        wait_for(1'b0, n);
        `CHK("first", 8'h07, vec)
        `CHK("kept", 1'b1, nreq[6])
        wait_for(1'b0, n);
        `CHK("second", 8'h06, vec)
    endtask

    task automatic t_xfer();
        int n;
        n2e[10]    <= 1'b1;
        ech[32:30] <= 3'h2;
        ld         <= 8'h04;
        @(posedge clk);
        ld <= 8'h00;
        for (int k = 0; k < 2; k++)
        begin
            pulse(96'h400, '0, '0);
            wait_for(1'b1, n);
            `CHK("steal", 2, n)
            `CHK("src", 24'h00_0100 + 2 * k, esrc)
            `CHK("dst", 24'h00_0200 + 2 * k, edst)
            `CHK("count", 8'h01 - k, ccnt[23:16])
        end
        wait_for(1'b0, n);
        `CHK("zero irq", 8'h0A, vec)
    endtask

    task automatic t_trap();
        int n;
        pulse('0, '0, 6'h02);
        wait_for(1'b0, n);
        `CHK("trap lat", 2, n)
        `CHK("trap vec", 8'h63, vec)
        `CHK("trap flag", 8'h08, tflag)
        pulse(96'h20, '0, 6'h10);
        pulse('0, '0, 6'h01);
        wait_for(1'b0, n);
        `CHK("nest vec", 8'h62, vec)
        wait_for(1'b0, n);
        `CHK("held vec", 8'h66, vec)
        wait_for(1'b0, n);
        `CHK("node after", 8'h05, vec)
        swn <= 8'h33;
        swt <= 1'b1;
        @(posedge clk);
        swt <= 1'b0;
        wait_for(1'b0, n);
        `CHK("sw trap", 8'h33, vec)
    endtask

    task automatic t_router();
        logic [3:0] cfg [5] = '{4'h9, 4'h5, 4'hD, 4'hE, 4'hF};
        int         exp [5] = '{1, 1, 2, 0, 2};
        int         hits;
        rte   <= 16'h0040;
        pmask <= 4'h1;
        pat   <= 4'h1;
        for (int m = 0; m < 5; m++)
        begin
            {rise[2], fall[2], gate[3:2]} <= cfg[m];
            hits = 0;
            repeat (2) @(posedge clk);
            for (int e = 0; e < 8; e++)
            begin
                if (e == 1) ein[2] <= 1'b1;
                if (e == 4) ein[2] <= 1'b0;
                @(posedge clk);
                hits += (evt[1] === 1'b1);
            end
            `CHK("events", exp[m], hits)
        end
        `CHK("router node", 1'b1, nreq[93])
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_vectored();
        t_xfer();
        t_trap();
        t_router();
        give_verdict();
    end

    // Generous margin over the run.
    initial
    begin
        #(50 * 5000);
        miscompares++;
        give_verdict();
    end
endmodule // testbench
